// File: core/cbiu_top.sv
// bus interface unit of a 32-bit cpu with a 16-bit data bus
//
// Summary of operation
// - two byte select outputs mark the upper and lower data lanes used.
// - bus cycles are always sixteen bits wide; no bus size input.
// - next address request is honoured on any kind of bus cycle, but only when another piece of the same access follows.
// - after reset the d register holds component id high, revision low.
// - coprocessor cycles drive the top address line high with i/o type.
// - code prefetch reads two bytes in one sixteen-bit bus cycle.
// - physical addresses are 24 bits wide, 16 Mb of memory.
// - float input puts every output and two-way pin in high impedance.
// - interrupts, coprocessor, busy, error, float inputs are synchronised.
// - two register address components add one clock.
// - misaligned word or even doubleword adds 2, read-modify-write 4.
// - odd doubleword adds 4 clocks, read-modify-write adds 8.
// - register operand takes smaller count, memory operand the larger.
// - address and control change at phase one, write data at phase two.
// - ready, hold, busy, error, request, read data sampled phase one; float at every edge.
// - next address request and interrupts are sampled at phase two.
`timescale 1ns/10ps
`include "cbiu_consts.svh"
module cbiu_top #(
   parameter logic [7:0] COMPONENT_ID = `CBIU_COMPONENT_ID, // arbitrary
   parameter logic [7:0] REVISION = `CBIU_REVISION // arbitrary
) (
   input wire logic clk_i, // double rate clock
   input wire logic rst_b_i, // synchronous reset, active low
   input wire logic req_valid_i, // core access request
   input cbiu_pkg::cbiu_req_t req_i, // access description
   input cbiu_pkg::cbiu_timing_t timing_i, // instruction counts
   output logic req_ready_o, // access may be taken
   output logic done_o, // access finished, one cycle
   output logic [31:0] rdata_o, // read result, low aligned
   output logic [7:0] penalty_o, // clock count of last access
   input wire logic dreg_we_i, // core writes the d register
   input wire logic [15:0] dreg_wdata_i, // d register write value
   output logic [15:0] general_register_d_o, // d register
   output cbiu_pkg::cbiu_bus_t bus_o, // address and control pins
   output logic pins_oe_o, // enable for bus_o and hold ack
   output logic hold_acknowledge_o, // bus given away
   output logic [`CBIU_DATA_W-1:0] data_o, // write data pins
   output logic data_oe_o, // data pin enable
   input wire logic [`CBIU_DATA_W-1:0] data_i, // read data pins
   input wire logic ready_n_i, // cycle end, active low
   input wire logic hold_i, // bus request from outside
   input wire logic next_address_request_n_i, // pipelining request
   input wire logic nmi_i, // non-maskable interrupt, async
   input wire logic maskable_interrupt_request_i, // async
   input wire logic coprocessor_operand_request_i, // async
   input wire logic busy_n_i, // coprocessor busy, async
   input wire logic error_n_i, // coprocessor error, async
   input wire logic float_request_n_i, // float all pins, async
   output logic nmi_o, // sampled nmi
   output logic maskable_interrupt_o, // sampled interrupt request
   output logic [2:0] coproc_status_o // request, busy, error
);
   localparam int AW = `CBIU_ADDR_W;
   logic ph_two;
   logic [`CBIU_ASYNC_W-1:0] async_s;
   logic float_s;
   cbiu_pkg::cbiu_state_t state, next_state;
   logic [AW-1:0] cur_a, next_a, step_a;
   logic [2:0] cur_n, next_n, tot_n, next_tot_n, len, rest;
   logic pipe, next_pipe, ea_seen, next_ea_seen;
   cbiu_pkg::cbiu_kind_t kind, next_kind;
   logic [31:0] wbuf, next_wbuf, rbuf, next_rbuf, next_rdata;
   cbiu_pkg::cbiu_bus_t next_bus;
   logic next_done, next_req_ready, next_hold_ack, next_pins_oe;
   logic [7:0] next_pen, pen_w;
   logic [15:0] next_dreg;
   logic [`CBIU_DATA_W-1:0] next_data;
   logic next_data_oe, next_nmi, next_irq;
   logic [2:0] next_coproc;

   // bytes moved by one bus cycle; odd start or last byte is single
   function automatic logic [2:0] piece_len(input logic [AW-1:0] a,
                                            input logic [2:0] n);
      piece_len = (a[0] || n == 3'h1) ? 3'h1 : 3'h2;
   endfunction

   function automatic logic is_wr(input cbiu_pkg::cbiu_kind_t k);
      is_wr = k == cbiu_pkg::K_MEM_WR || k == cbiu_pkg::K_IO_WR ||
              k == cbiu_pkg::K_COP_WR;
   endfunction

   function automatic logic is_cop(input cbiu_pkg::cbiu_kind_t k);
      is_cop = k == cbiu_pkg::K_COP_RD || k == cbiu_pkg::K_COP_WR;
   endfunction

   // address phase pins of one piece, strobe asserted
   function automatic cbiu_pkg::cbiu_bus_t make_bus(
         input logic [AW-1:0] a, input logic [2:0] n,
         input cbiu_pkg::cbiu_kind_t k, input logic lk);
      cbiu_pkg::cbiu_bus_t b;
      logic word;
      word = piece_len(a, n) == 3'h2;
      b.addr = a[AW-1:1];
      // lanes from size and bit zero
      b.upper_byte_select_n = !(word || a[0]);
      b.lower_byte_select_n = a[0];
      b.address_strobe_n = 1'b0;
      b.write = is_wr(k);
      b.data_cycle = k != cbiu_pkg::K_FETCH;
      b.mem_cycle = k == cbiu_pkg::K_MEM_RD || k == cbiu_pkg::K_MEM_WR ||
                    k == cbiu_pkg::K_FETCH;
      b.lock_n = !lk;
      if (is_cop(k)) begin
         b.addr[AW-2] = 1'b1;
      end
      make_bus = b;
   endfunction

   // sync async pins, active low ones inverted first
   cbiu_sync #(.W(`CBIU_ASYNC_W)) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i({nmi_i, maskable_interrupt_request_i,
                coprocessor_operand_request_i, !busy_n_i, !error_n_i,
                !float_request_n_i}),
      .sync_o(async_s)
   );
   assign float_s = async_s[0];

   cbiu_penalty u_penalty (
      .timing_i(timing_i),
      .addr_odd_i(req_i.addr[0]),
      .nbytes_i(req_i.nbytes),
      .clocks_o(pen_w)
   );

   // bus sequencer: state moves only on edges that open phase one
   always_comb begin
      next_state = state;
      next_a = cur_a;
      next_n = cur_n;
      next_tot_n = tot_n;
      next_pipe = pipe;
      next_ea_seen = ea_seen;
      next_kind = kind;
      next_wbuf = wbuf;
      next_rbuf = rbuf;
      next_rdata = rdata_o;
      next_bus = bus_o;
      next_done = 1'b0;
      next_pen = penalty_o;
      next_hold_ack = hold_acknowledge_o;
      len = piece_len(cur_a, cur_n);
      rest = cur_n - len;
      step_a = cur_a + {{(AW-3){1'b0}}, len};
      next_dreg = dreg_we_i ? dreg_wdata_i : general_register_d_o;
      // next address sampled at phase two
      if (!ph_two && (state == cbiu_pkg::ST_T1 || state == cbiu_pkg::ST_T2)
          && !next_address_request_n_i) begin
         next_ea_seen = 1'b1;
      end
      if (ph_two) begin
         case (state)
            cbiu_pkg::ST_IDLE: begin
               if (hold_i) begin
                  next_state = cbiu_pkg::ST_HOLD;
                  next_hold_ack = 1'b1;
               end else if (req_valid_i && req_ready_o) begin
                  next_kind = req_i.kind;
                  next_wbuf = req_i.wdata;
                  next_pen = pen_w;
                  next_ea_seen = 1'b0;
                  if (req_i.kind == cbiu_pkg::K_FETCH) begin
                     next_a = {req_i.addr[AW-1:1], 1'b0};
                     next_n = 3'h2;
                  end else begin
                     next_a = req_i.addr;
                     next_n = req_i.nbytes;
                  end
                  next_tot_n = next_n;
                  next_bus = make_bus(next_a, next_n, req_i.kind, req_i.lock);
                  next_state = cbiu_pkg::ST_T1;
               end
            end
            cbiu_pkg::ST_T1: begin
               next_bus.address_strobe_n = 1'b1;
               next_state = cbiu_pkg::ST_T2;
            end
            cbiu_pkg::ST_T2: begin
               next_bus.address_strobe_n = 1'b1;
               // ready and read data at phase one
               if (!ready_n_i) begin
                  next_rbuf = (len == 3'h2) ? {data_i, rbuf[31:16]} :
                     {(cur_a[0] ? data_i[15:8] : data_i[7:0]), rbuf[31:8]};
                  next_wbuf = (len == 3'h2) ? {16'h0000, wbuf[31:16]} :
                                              {8'h00, wbuf[31:8]};
                  next_ea_seen = 1'b0;
                  if (rest != 3'h0) begin
                     next_a = step_a;
                     next_n = rest;
                     if (pipe) begin
                        next_pipe = 1'b0;
                     end else begin
                        next_bus = make_bus(step_a, rest, kind, !bus_o.lock_n);
                        next_state = cbiu_pkg::ST_T1;
                     end
                  end else begin
                     case (tot_n)
                        3'h1: next_rdata = {24'h000000, next_rbuf[31:24]};
                        3'h2: next_rdata = {16'h0000, next_rbuf[31:16]};
                        default: next_rdata = next_rbuf;
                     endcase
                     next_done = 1'b1;
                     next_pipe = 1'b0;
                     next_bus.lock_n = 1'b1;
                     next_state = cbiu_pkg::ST_IDLE;
                  end
               end else if (!pipe && ea_seen && rest != 3'h0) begin
                  // early address on any cycle kind
                  next_bus = make_bus(step_a, rest, kind, !bus_o.lock_n);
                  next_pipe = 1'b1;
                  next_ea_seen = 1'b0;
               end
            end
            cbiu_pkg::ST_HOLD: begin
               if (!hold_i) begin
                  next_state = cbiu_pkg::ST_IDLE;
                  next_hold_ack = 1'b0;
               end
            end
            default: next_state = cbiu_pkg::ST_IDLE;
         endcase
      end
      // float and hold release the pins
      next_pins_oe = ph_two ? (!float_s && next_state != cbiu_pkg::ST_HOLD)
                            : (pins_oe_o && !float_s);
      // offered only for phase two cycles so a take opens phase one
      next_req_ready = next_state == cbiu_pkg::ST_IDLE && !ph_two;
   end

   // sequencer registers; bus_o moves at phase one only, done_o is high in phase one only
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ph_two <= 1'b0;
         state <= cbiu_pkg::ST_IDLE;
         cur_a <= '0;
         cur_n <= 3'h0;
         tot_n <= 3'h0;
         pipe <= 1'b0;
         ea_seen <= 1'b0;
         kind <= cbiu_pkg::K_MEM_RD;
         wbuf <= 32'h00000000;
         rbuf <= 32'h00000000;
         rdata_o <= 32'h00000000;
         bus_o <= '{addr: '0, default: 1'b1};
         done_o <= 1'b0;
         penalty_o <= 8'h00;
         hold_acknowledge_o <= 1'b0;
         pins_oe_o <= 1'b0;
         req_ready_o <= 1'b0;
         general_register_d_o <= {COMPONENT_ID, REVISION};
      end else begin
         ph_two <= !ph_two;
         state <= next_state;
         cur_a <= next_a;
         cur_n <= next_n;
         tot_n <= next_tot_n;
         pipe <= next_pipe;
         ea_seen <= next_ea_seen;
         kind <= next_kind;
         wbuf <= next_wbuf;
         rbuf <= next_rbuf;
         rdata_o <= next_rdata;
         bus_o <= next_bus;
         done_o <= next_done;
         penalty_o <= next_pen;
         hold_acknowledge_o <= next_hold_ack;
         pins_oe_o <= next_pins_oe;
         req_ready_o <= next_req_ready;
         general_register_d_o <= next_dreg;
      end
   end

   // write data and sampled side inputs
   always_comb begin
      next_data = data_o;
      next_data_oe = data_oe_o;
      next_nmi = nmi_o;
      next_irq = maskable_interrupt_o;
      next_coproc = coproc_status_o;
      if (!ph_two) begin
         // write data moves at phase two; lanes fixed at 16
         next_data = (len == 3'h2) ? wbuf[15:0] :
            (cur_a[0] ? {wbuf[7:0], 8'h00} : {8'h00, wbuf[7:0]});
         next_data_oe = (state == cbiu_pkg::ST_T1 ||
                         state == cbiu_pkg::ST_T2) && is_wr(kind);
         next_nmi = async_s[5];
         next_irq = async_s[4];
      end else begin
         next_coproc = async_s[3:1];
      end
      if (float_s) begin
         next_data_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         data_o <= '0;
         data_oe_o <= 1'b0;
         nmi_o <= 1'b0;
         maskable_interrupt_o <= 1'b0;
         coproc_status_o <= 3'h0;
      end else begin
         data_o <= next_data;
         data_oe_o <= next_data_oe;
         nmi_o <= next_nmi;
         maskable_interrupt_o <= next_irq;
         coproc_status_o <= next_coproc;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_early_addr;
      state == cbiu_pkg::ST_T2 && ph_two && ready_n_i && !pipe && ea_seen &&
      rest != 3'h0;
   endsequence
   sequence s_strobe_pulse;
      !bus_o.address_strobe_n ##2 bus_o.address_strobe_n;
   endsequence

   property p_phase_one_pins;
      $changed(bus_o) |-> !ph_two;
   endproperty
   a_phase_one_pins: assert property (p_phase_one_pins)
      else $error("address pins changed outside phase one");
   property p_phase_two_data;
      $changed(data_o) |-> ph_two;
   endproperty
   a_phase_two_data: assert property (p_phase_two_data)
      else $error("write data changed outside phase two");
   property p_float;
      float_s && ph_two |=> !pins_oe_o && !data_oe_o;
   endproperty
   a_float: assert property (p_float)
      else $error("pins still driven while floating");
   property p_lane_select;
      !bus_o.address_strobe_n |->
         !(bus_o.upper_byte_select_n && bus_o.lower_byte_select_n);
   endproperty
   a_lane_select: assert property (p_lane_select)
      else $error("address strobe with no byte select");
   property p_coproc;
      !bus_o.address_strobe_n && is_cop(kind) |->
         bus_o.addr[AW-2] && !bus_o.mem_cycle;
   endproperty
   a_coproc: assert property (p_coproc)
      else $error("coprocessor cycle without select pattern");
   property p_fetch_word;
      !bus_o.address_strobe_n && kind == cbiu_pkg::K_FETCH |->
         !bus_o.upper_byte_select_n && !bus_o.lower_byte_select_n;
   endproperty
   a_fetch_word: assert property (p_fetch_word)
      else $error("prefetch not a full word");
   property p_reset_id;
      $rose(rst_b_i) |-> general_register_d_o == {COMPONENT_ID, REVISION};
   endproperty
   a_reset_id: assert property (p_reset_id)
      else $error("identification missing after reset");
   property p_ready_phase;
      done_o |-> !ph_two;
   endproperty
   a_ready_phase: assert property (p_ready_phase)
      else $error("cycle ended off phase one");
   property p_ea_phase;
      $rose(ea_seen) |-> ph_two;
   endproperty
   a_ea_phase: assert property (p_ea_phase)
      else $error("next address sampled off phase two");
   property p_pipeline;
      s_early_addr |=> s_strobe_pulse;
   endproperty
   a_pipeline: assert property (p_pipeline)
      else $error("next address request not honoured");
endmodule

// File: shared/cbiu_consts.svh
// constant values for the sixteen-bit cpu bus interface
`ifndef CBIU_CONSTS_SVH
`define CBIU_CONSTS_SVH
// physical address and data bus widths
`define CBIU_ADDR_W 24
`define CBIU_DATA_W 16
// reset identification in the d register, values are arbitrary
`define CBIU_COMPONENT_ID 8'h5a
`define CBIU_REVISION 8'h01
// extra processor clocks added to the base count
`define CBIU_PEN_TWO_REG 8'h01
`define CBIU_PEN_MIS 8'h02
`define CBIU_PEN_MIS_RMW 8'h04
`define CBIU_PEN_ODD32 8'h04
`define CBIU_PEN_ODD32_RMW 8'h08
// async inputs: nmi, maskable_interrupt_request, coproc request, busy, error, float
`define CBIU_ASYNC_W 6
`endif

// File: shared/cbiu_pkg.sv
// types shared by the sixteen-bit cpu bus interface
`include "cbiu_consts.svh"
package cbiu_pkg;
   // kind of access asked for by the execution core
   typedef enum logic [2:0] {
      K_MEM_RD, K_MEM_WR, K_IO_RD, K_IO_WR, K_FETCH, K_COP_RD, K_COP_WR
   } cbiu_kind_t;
   // bus sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_T2, ST_HOLD} cbiu_state_t;
   // one access from the core
   typedef struct packed {
      cbiu_kind_t kind;
      logic lock;
      logic [2:0] nbytes;
      logic [`CBIU_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } cbiu_req_t;
   // clock count figures of the instruction issuing the access
   typedef struct packed {
      logic [7:0] base_reg;
      logic [7:0] base_mem;
      logic mem_operand;
      logic two_reg;
      logic rmw;
   } cbiu_timing_t;
   // address and cycle definition pins
   typedef struct packed {
      logic [`CBIU_ADDR_W-2:0] addr;
      logic upper_byte_select_n;
      logic lower_byte_select_n;
      logic address_strobe_n;
      logic write;
      logic data_cycle;
      logic mem_cycle;
      logic lock_n;
   } cbiu_bus_t;
endpackage

// File: core/cbiu_sync.sv
// two flip-flop synchroniser for inputs asynchronous to the clock
`timescale 1ns/10ps
`include "cbiu_consts.svh"
module cbiu_sync #(
   parameter int W = `CBIU_ASYNC_W
) (
   input wire logic clk_i, // double rate clock
   input wire logic rst_b_i, // synchronous reset, active low
   input wire logic [W-1:0] async_i, // asynchronous levels, active high
   output logic [W-1:0] sync_o // synchronised levels
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // first stage is read only by the second stage
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule

// File: core/cbiu_penalty.sv
// clock count of an access: base count plus address penalties
`timescale 1ns/10ps
`include "cbiu_consts.svh"
module cbiu_penalty (
   input cbiu_pkg::cbiu_timing_t timing_i, // counts and operand flags
   input wire logic addr_odd_i, // operand address is odd
   input wire logic [2:0] nbytes_i, // operand size in bytes
   output logic [7:0] clocks_o // total processor clocks
);
   logic [7:0] base;
   logic [7:0] ea_extra;
   logic [7:0] align_extra;

   always_comb begin
      base = timing_i.mem_operand ? timing_i.base_mem : timing_i.base_reg;
      ea_extra = timing_i.two_reg ? `CBIU_PEN_TWO_REG : 8'h00;
      align_extra = 8'h00;
      if (timing_i.mem_operand) begin
         if (nbytes_i == 3'h4 && addr_odd_i) begin
            align_extra = timing_i.rmw ? `CBIU_PEN_ODD32_RMW
                                       : `CBIU_PEN_ODD32;
         end else if (nbytes_i == 3'h4 || (nbytes_i == 3'h2 && addr_odd_i)) begin
            align_extra = timing_i.rmw ? `CBIU_PEN_MIS_RMW : `CBIU_PEN_MIS;
         end
      end
      // saturating is not needed: base counts stay far below the limit
      clocks_o = 8'(base + ea_extra + align_extra);
   end
endmodule

// File: verification/cbiu_mem_model.sv
// memory and i/o partner answering the bus cycles of the interface
`timescale 1ns/10ps
module cbiu_mem_model (
   input wire logic clk_i, // double rate clock
   input wire logic rst_b_i, // synchronous reset, active low
   input cbiu_pkg::cbiu_bus_t bus_i, // address and control pins
   input wire logic pins_oe_i, // address pins driven
   input wire logic [15:0] wdata_i, // write data pins
   input wire logic [3:0] waits_i, // wait states per piece
   output logic ready_n_o, // cycle end, active low
   output logic [15:0] rdata_o, // read data pins
   output logic [7:0] pieces_o, // strobes seen
   output cbiu_pkg::cbiu_bus_t last_bus_o // pins at last strobe
);
   logic [15:0] mem [0:255];
   cbiu_pkg::cbiu_bus_t prev;
   cbiu_pkg::cbiu_bus_t cur_q[$];
   int due_q[$];
   int cyc = 0;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 'h301) ^ 16'h5aa5;
   // one queue entry per strobe; the head ends at its due edge
   always @(posedge clk_i) begin
      int due;
      cyc++;
      if (!rst_b_i) begin
         due_q.delete();
         cur_q.delete();
         pieces_o <= 8'h00;
      end else begin
         // pipelined strobe may come before the head ends
         if (pins_oe_i && !bus_i.address_strobe_n &&
               (prev.address_strobe_n || prev != bus_i)) begin
            due = cyc + 3 + 2 * waits_i;
            if (due_q.size() > 0 && due <= due_q[$])
               due = due_q[$] + 2 + 2 * waits_i;
            due_q.push_back(due);
            cur_q.push_back(bus_i);
            pieces_o <= pieces_o + 8'h01;
            last_bus_o <= bus_i;
         end
         // write data is still held at the edge that ends the piece
         if (due_q.size() > 0 && cyc == due_q[0]) begin
            if (cur_q[0].write && !cur_q[0].lower_byte_select_n)
               mem[cur_q[0].addr[7:0]][7:0] = wdata_i[7:0];
            if (cur_q[0].write && !cur_q[0].upper_byte_select_n)
               mem[cur_q[0].addr[7:0]][15:8] = wdata_i[15:8];
            due_q.pop_front();
            cur_q.pop_front();
         end
      end
      prev = bus_i;
      // ready low two cycles so exactly one sampling edge sees it
      if (due_q.size() > 0 && cyc >= due_q[0] - 2) begin
         ready_n_o <= 1'b0;
         rdata_o <= cur_q[0].write ? ~rdata_o : mem[cur_q[0].addr[7:0]];
      end else begin
         ready_n_o <= 1'b1;
         rdata_o <= ~rdata_o; // released lines never look stable
      end
   end
endmodule

// File: verification/tb_cbiu_top.sv
// self-checking bench of the bus interface against the memory model
`timescale 1ns/10ps
module tb_cbiu_top;
   logic clk = 0, rst_b = 0, req_valid = 0, ready, done, dreg_we = 0;
   cbiu_pkg::cbiu_req_t req = '0;
   cbiu_pkg::cbiu_timing_t tim = '0;
   cbiu_pkg::cbiu_bus_t bus, lbus;
   logic [31:0] rdata;
   logic [15:0] dreg_wd = 0, dreg, dout, din, sh [0:255];
   logic [7:0] pen, pieces, p0, np;
   logic pins_oe, h_ack, doe, ready_n, nmi_o, irq_o, hold = 0, ea_n = 1;
   logic nmi = 0, irq = 0, preq = 0, busy_n = 1, err_n = 1, fl_n = 1;
   logic [2:0] cst;
   logic [3:0] waits = 0;
   int error_cnt = 0, checked = 0;
   always #2 clk = ~clk;
   cbiu_top #(.COMPONENT_ID(8'h3c), .REVISION(8'h07)) u_cbiu_top (
      .clk_i(clk), .rst_b_i(rst_b), .req_valid_i(req_valid), .req_i(req),
      .timing_i(tim), .req_ready_o(ready), .done_o(done), .rdata_o(rdata),
      .penalty_o(pen), .dreg_we_i(dreg_we), .dreg_wdata_i(dreg_wd),
      .general_register_d_o(dreg), .bus_o(bus), .pins_oe_o(pins_oe),
      .hold_acknowledge_o(h_ack), .data_o(dout), .data_oe_o(doe),
      .data_i(din), .ready_n_i(ready_n), .hold_i(hold),
      .next_address_request_n_i(ea_n), .nmi_i(nmi),
      .maskable_interrupt_request_i(irq),
      .coprocessor_operand_request_i(preq), .busy_n_i(busy_n),
      .error_n_i(err_n), .float_request_n_i(fl_n), .nmi_o(nmi_o),
      .maskable_interrupt_o(irq_o), .coproc_status_o(cst));
   cbiu_mem_model u_cbiu_mem_model (.clk_i(clk), .rst_b_i(rst_b),
      .bus_i(bus), .pins_oe_i(pins_oe), .wdata_i(dout), .waits_i(waits),
      .ready_n_o(ready_n), .rdata_o(din), .pieces_o(pieces),
      .last_bus_o(lbus));
   initial for (int i = 0; i < 256; i++) sh[i] = 16'(i * 'h301) ^ 16'h5aa5;
   function automatic logic [7:0] shb(input logic [23:0] x);
      return x[0] ? sh[x[8:1]][15:8] : sh[x[8:1]][7:0];
   endfunction
   function automatic logic [31:0] exp_rd(input logic [23:0] a,
         input logic [2:0] n);
      logic [31:0] r;
      r = {shb(a + 3), shb(a + 2), shb(a + 1), shb(a)};
      return n == 4 ? r : n == 2 ? r & 32'hffff : r & 32'hff;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one core access, held until taken, then wait for the done pulse
   task automatic acc(input cbiu_pkg::cbiu_kind_t k, input logic [2:0] n,
         input logic [23:0] a, input logic [31:0] w);
      int i;
      p0 = pieces;
      req = '{kind: k, lock: 1'b0, nbytes: n, addr: a, wdata: w};
      req_valid = 1'b1;
      for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
      chk("done", 1, done);
      np = pieces - p0;
      if (!(k inside {cbiu_pkg::K_MEM_WR, cbiu_pkg::K_IO_WR,
            cbiu_pkg::K_COP_WR})) return;
      for (i = 0; i < n; i++) sh[(a + i) >> 1][(a[0] ^ i[0]) * 8 +: 8] =
         w[i * 8 +: 8];
   endtask
   task automatic t_id();
      chk("dreg", 16'h3c07, dreg);
      dreg_we = 1;
      dreg_wd = 16'h1234;
      cyc(1);
      dreg_we = 0;
      chk("dreg wr", 16'h1234, dreg);
      rst_b = 0;
      cyc(4);
      rst_b = 1;
      cyc(4);
      chk("dreg rst", 16'h3c07, dreg);
      $display("test id finished");
   endtask
   task automatic t_lanes();
      logic [23:0] ad [3] = '{24'hfff010, 24'hfff011, 24'hfff010};
      logic [2:0] nb [3] = '{1, 1, 2};
      logic [1:0] se [3] = '{2'b10, 2'b01, 2'b00};
      for (int i = 0; i < 3; i++) begin
         acc(cbiu_pkg::K_MEM_RD, nb[i], ad[i], 0);
         chk("pieces", 1, np);
         chk("sel", se[i], {lbus.upper_byte_select_n,
            lbus.lower_byte_select_n});
         chk("addr", ad[i][23:1], lbus.addr);
         chk("mio", 1, lbus.mem_cycle);
         chk("rdata", exp_rd(ad[i], nb[i]), rdata);
      end
      $display("test lanes finished");
   endtask
   task automatic t_pen();
      int r [9][7] = '{'{2, 0, 1, 0, 0, 1, 6}, '{2, 0, 0, 0, 0, 1, 2},
         '{2, 0, 1, 1, 0, 1, 7}, '{2, 1, 1, 0, 0, 2, 8},
         '{2, 1, 1, 0, 1, 2, 10}, '{4, 0, 1, 0, 0, 2, 8},
         '{4, 0, 1, 0, 1, 2, 10}, '{4, 1, 1, 0, 0, 3, 10},
         '{4, 1, 1, 0, 1, 3, 14}};
      for (int i = 0; i < 9; i++) begin
         tim = '{base_reg: 8'h02, base_mem: 8'h06, mem_operand: r[i][2],
            two_reg: r[i][3], rmw: r[i][4]};
         acc(cbiu_pkg::K_MEM_RD, 3'(r[i][0]), 24'h60 + r[i][1], 0);
         chk("pieces", r[i][5], np);
         chk("penalty", r[i][6], pen);
         chk("rdata", exp_rd(24'h60 + r[i][1], 3'(r[i][0])), rdata);
      end
      $display("test penalty finished");
   endtask
   task automatic t_wr();
      acc(cbiu_pkg::K_MEM_WR, 1, 24'h21, 32'hc3);
      acc(cbiu_pkg::K_MEM_RD, 2, 24'h20, 0);
      chk("byte wr", exp_rd(24'h20, 2), rdata);
      ea_n = 0;
      acc(cbiu_pkg::K_MEM_WR, 4, 24'h33, 32'h8badf00d);
      waits = 2;
      acc(cbiu_pkg::K_MEM_RD, 4, 24'h33, 0);
      chk("dword wr", exp_rd(24'h33, 4), rdata);
      ea_n = 1;
      waits = 0;
      $display("test write finished");
   endtask
   task automatic t_kinds();
      cbiu_pkg::cbiu_kind_t k [4] = '{cbiu_pkg::K_IO_RD, cbiu_pkg::K_IO_WR,
         cbiu_pkg::K_COP_RD, cbiu_pkg::K_COP_WR};
      for (int i = 0; i < 4; i++) begin
         acc(k[i], 2, 24'h80, 0);
         chk("top addr", i / 2, lbus.addr[22]);
         chk("mio", 0, lbus.mem_cycle);
         chk("write", i % 2, lbus.write);
      end
      acc(cbiu_pkg::K_FETCH, 2, 24'h51, 0);
      chk("fetch pieces", 1, np);
      chk("fetch sel", 0, {lbus.upper_byte_select_n,
         lbus.lower_byte_select_n});
      chk("fetch data", sh[8'h28], rdata[15:0]);
      $display("test kinds finished");
   endtask
   task automatic t_pins();
      fl_n = 0;
      cyc(8);
      chk("float oe", 0, {pins_oe, doe});
      fl_n = 1;
      cyc(8);
      chk("oe back", 1, pins_oe);
      {nmi, irq, preq, busy_n, err_n} = 5'b11100;
      cyc(1);
      chk("nmi early", 0, nmi_o);
      cyc(8);
      chk("async", 5'h1f, {nmi_o, irq_o, cst});
      {nmi, irq, preq, busy_n, err_n} = 5'b00011;
      hold = 1;
      cyc(8);
      chk("async off", 0, {nmi_o, irq_o, cst});
      chk("hold", 2'b10, {h_ack, ready});
      hold = 0;
      cyc(8);
      chk("hold off", 0, h_ack);
      $display("test pins finished");
   endtask
   task automatic wrap_up();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // main sequence: reset held four cycles, then every scenario
   initial begin
      cyc(4);
      rst_b = 1;
      cyc(4);
      t_id();
      t_lanes();
      t_pen();
      t_wr();
      t_kinds();
      t_pins();
      wrap_up();
   end
   // watchdog far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
endmodule
